//--- gpio_port_consts.vh
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH
// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_MODE_BASE 12'h000
`define ADDR_MODE_LAST 12'h02C
`define ADDR_DATA 12'h030
`define ADDR_SET 12'h034
`define ADDR_CLR 12'h038
`define ADDR_PAD_CTRL 12'h03C
`define ADDR_SYS_CTRL 12'h040
// ****************************************************************
// field positions and codes
// ****************************************************************
`define MODE_W 16
`define FID_W 5
`define FID_LSB 0
`define DIR_LSB 8
`define DIR_W 2
`define DIR_IN 2'h0
`define DIR_PU 2'h1
`define DIR_PD 2'h2
`define DIR_OUT 2'h3
`define FID_GPIO 5'h00
`define FID_ANALOG 5'h01
`define PAD_REDUCED_BIT 0
`define SYS_DBG_LSB 0
`define SYS_DBG_W 2
`define SYS_HWR_OFF_BIT 2
`define DBG_OFF 2'h0
`define DBG_ON_DEFAULT 2'h1
`define DBG_ON_ALT1 2'h2
`define DBG_ON_ALT2 2'h3
// ****************************************************************
// fixed pin numbers
// ****************************************************************
`define PIN_HW_RESET 0
`define PIN_DBG_CLK 2
`define PIN_DBG_DATA 5
`define PIN_DBG_ALT1 1
`define PIN_DBG_ALT2 10
`define PIN_ADC0 1
`define PIN_ADC1 2
`define PIN_ADC2 6
`define PIN_ADC3 7
// decoder default pins, one nibble per channel, channel 0 lowest
`define QDEC_CH 6
`define QDEC_DEF_A 24'h097531
`define QDEC_DEF_B 24'h8AB642
`define QSEL_DEFAULT 4'hF
`define QSEL_W 4
`endif

//--- pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-stage synchroniser for asynchronous pin levels
// ****************************************************************
module pin_sync #(
    parameter W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // pin_sync
`default_nettype wire

//--- periph_in_select.v
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_consts.vh"
// ****************************************************************
// peripheral input routing, lowest pin number wins
// ****************************************************************
module periph_in_select #(
    parameter NPINS = 12,
    parameter NIDS = 32
) (
    input wire [NPINS*`FID_W-1:0] pin_fid,
    input wire [NPINS-1:0] pin_lvl,
    input wire [NPINS-1:0] pin_en,
    output reg [NIDS-1:0] id_lvl,
    output reg [NIDS-1:0] id_hit
);
    integer k;
    integer i;
    always @* begin
        id_lvl = {NIDS{1'b0}};
        id_hit = {NIDS{1'b0}};
        for (k = 0; k < NIDS; k = k + 1) begin
            // walk downward so the lowest matching pin is written last
            for (i = NPINS - 1; i >= 0; i = i - 1) begin
                if (pin_en[i] && pin_fid[i*`FID_W +: `FID_W] == k[`FID_W-1:0]) begin
                    id_lvl[k] = pin_lvl[i];
                    id_hit[k] = 1'b1;
                end
            end
        end
    end
endmodule // periph_in_select
`default_nettype wire

//--- gpio_port_pin_mux.v
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_consts.vh"
module gpio_port_pin_mux #(
    parameter NPINS = 12,
    parameter BONDED = 12,
    parameter NIDS = 32
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [NPINS-1:0] pin_in,
    output reg [NPINS-1:0] pin_out,
    output reg [NPINS-1:0] pin_oe,
    output reg [NPINS-1:0] pin_pu,
    output reg [NPINS-1:0] pin_pd,
    output reg pad_drive_reduced,
    output reg [3:0] adc_chan_en,
    input wire [NIDS-1:0] periph_out,
    output reg [NIDS-1:0] periph_in,
    output reg [NIDS-1:0] periph_in_hit,
    input wire debug_data_out,
    input wire debug_data_oe,
    output reg debug_data_in,
    output reg debug_clk,
    output reg hw_reset_req,
    input wire [`QDEC_CH*2*`QSEL_W-1:0] decoder_channel_pin_select,
    output reg [`QDEC_CH-1:0] decoder_phase_a,
    output reg [`QDEC_CH-1:0] decoder_phase_b,
    input wire sleep_req
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    function [`FID_W-1:0] fid_of;
        input [NPINS*`MODE_W-1:0] modes;
        input integer p;
        begin
            fid_of = modes[p*`MODE_W + `FID_LSB +: `FID_W];
        end
    endfunction

    function [`DIR_W-1:0] dir_of;
        input [NPINS*`MODE_W-1:0] modes;
        input integer p;
        begin
            dir_of = modes[p*`MODE_W + `DIR_LSB +: `DIR_W];
        end
    endfunction

    function is_adc_pin;
        input integer p;
        begin
            is_adc_pin = (p == `PIN_ADC0) || (p == `PIN_ADC1) ||
                (p == `PIN_ADC2) || (p == `PIN_ADC3);
        end
    endfunction

    function pick_pin;
        input [NPINS-1:0] lvl;
        input [`QSEL_W-1:0] sel;
        begin
            if (sel < NPINS) begin
                pick_pin = lvl[sel];
            end else begin
                pick_pin = 1'b0;
            end
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    reg [NPINS*`MODE_W-1:0] mode_r;
    reg [NPINS-1:0] out_latch_r;
    reg drive_reduced_r;
    reg [`SYS_DBG_W-1:0] debug_pin_select_r;
    reg hw_reset_pin_off_r;
    wire [NPINS-1:0] pin_lvl;
    wire [NPINS-1:0] bonded_mask;
    wire [NIDS-1:0] id_lvl;
    wire [NIDS-1:0] id_hit;
    reg [NPINS-1:0] analog_sel;
    reg [NPINS-1:0] route_en;
    reg [NPINS*`FID_W-1:0] fid_flat;
    reg [NPINS-1:0] out_nxt;
    reg [NPINS-1:0] oe_nxt;
    reg [NPINS-1:0] pu_nxt;
    reg [NPINS-1:0] pd_nxt;
    reg [3:0] adc_nxt;
    reg [NPINS-1:0] data_view;
    reg dbg_data_nxt;
    integer dbg_pin;
    integer i;
    integer c;
    reg [`QSEL_W-1:0] sel_a;
    reg [`QSEL_W-1:0] sel_b;
    reg [`QDEC_CH-1:0] qa_nxt;
    reg [`QDEC_CH-1:0] qb_nxt;
    reg [31:0] rdata_nxt;
    reg err_nxt;
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    wire rd_map;
    localparam [`QDEC_CH*`QSEL_W-1:0] QDEF_A = `QDEC_DEF_A;
    localparam [`QDEC_CH*`QSEL_W-1:0] QDEF_B = `QDEC_DEF_B;

    // unbonded pins never drive and read low except at the debug and reset inputs
    assign bonded_mask = (BONDED >= NPINS) ? {NPINS{1'b1}} :
        ({NPINS{1'b1}} >> (NPINS - BONDED));

    // ****************************************************************
    // pin input synchronisation
    // ****************************************************************
    pin_sync #(
        .W(NPINS)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pin_lvl)
    );

    // ****************************************************************
    // register writes
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= {NPINS*`MODE_W{1'b0}};
            out_latch_r <= {NPINS{1'b0}};
            drive_reduced_r <= 1'b0;
            debug_pin_select_r <= `DBG_ON_DEFAULT;
            hw_reset_pin_off_r <= 1'b0;
        end else if (wr_en) begin
            if (paddr <= `ADDR_MODE_LAST && paddr[1:0] == 2'h0) begin
                mode_r[paddr[5:2]*`MODE_W +: `MODE_W] <= pwdata[`MODE_W-1:0];
            end else if (paddr == `ADDR_DATA) begin
                out_latch_r <= pwdata[NPINS-1:0];
            end else if (paddr == `ADDR_SET) begin
                out_latch_r <= out_latch_r | pwdata[NPINS-1:0];
            end else if (paddr == `ADDR_CLR) begin
                out_latch_r <= out_latch_r & ~pwdata[NPINS-1:0];
            end else if (paddr == `ADDR_PAD_CTRL) begin
                drive_reduced_r <= pwdata[`PAD_REDUCED_BIT];
            end else if (paddr == `ADDR_SYS_CTRL) begin
                debug_pin_select_r <= pwdata[`SYS_DBG_LSB +: `SYS_DBG_W];
                hw_reset_pin_off_r <= pwdata[`SYS_HWR_OFF_BIT];
            end
        end
    end

    // ****************************************************************
    // pad multiplexer
    // ****************************************************************
    always @* begin
        case (debug_pin_select_r)
            `DBG_ON_ALT1: dbg_pin = `PIN_DBG_ALT1;
            `DBG_ON_ALT2: dbg_pin = `PIN_DBG_ALT2;
            default: dbg_pin = `PIN_DBG_DATA;
        endcase
        adc_nxt = 4'h0;
        for (i = 0; i < NPINS; i = i + 1) begin
            analog_sel[i] = is_adc_pin(i) && fid_of(mode_r, i) == `FID_ANALOG;
            fid_flat[i*`FID_W +: `FID_W] = fid_of(mode_r, i);
            route_en[i] = bonded_mask[i] && !analog_sel[i] &&
                dir_of(mode_r, i) != `DIR_OUT;
            oe_nxt[i] = dir_of(mode_r, i) == `DIR_OUT && !analog_sel[i];
            if (fid_of(mode_r, i) == `FID_GPIO) begin
                out_nxt[i] = out_latch_r[i];
            end else begin
                // no exclusivity check; every pin on this id follows it
                out_nxt[i] = periph_out[fid_of(mode_r, i)];
            end
            pu_nxt[i] = dir_of(mode_r, i) == `DIR_PU;
            pd_nxt[i] = dir_of(mode_r, i) == `DIR_PD;
            if (oe_nxt[i] || analog_sel[i]) begin
                pu_nxt[i] = 1'b0;
                pd_nxt[i] = 1'b0;
            end
            data_view[i] = analog_sel[i] ? 1'b0 : pin_lvl[i];
        end
        adc_nxt[0] = analog_sel[`PIN_ADC0];
        adc_nxt[1] = analog_sel[`PIN_ADC1];
        adc_nxt[2] = analog_sel[`PIN_ADC2];
        adc_nxt[3] = analog_sel[`PIN_ADC3];
        if (debug_pin_select_r != `DBG_OFF) begin
            oe_nxt[`PIN_DBG_CLK] = 1'b0;
            oe_nxt[dbg_pin] = debug_data_oe;
            out_nxt[dbg_pin] = debug_data_out;
            route_en[`PIN_DBG_CLK] = 1'b0;
            route_en[dbg_pin] = 1'b0;
        end
        if (!hw_reset_pin_off_r) begin
            // reset pin must stay an input or it could reset itself
            oe_nxt[`PIN_HW_RESET] = 1'b0;
            route_en[`PIN_HW_RESET] = 1'b0;
        end
        oe_nxt = oe_nxt & bonded_mask;
        // debugger drive overrides the mode, so pulls follow the final enable
        pu_nxt = pu_nxt & ~oe_nxt;
        pd_nxt = pd_nxt & ~oe_nxt;
        data_view = data_view & bonded_mask;
        dbg_data_nxt = pin_lvl[dbg_pin];
    end

    // ****************************************************************
    // decoder pin selection
    // ****************************************************************
    always @* begin
        for (c = 0; c < `QDEC_CH; c = c + 1) begin
            sel_a = decoder_channel_pin_select[c*2*`QSEL_W +: `QSEL_W];
            sel_b = decoder_channel_pin_select[(c*2+1)*`QSEL_W +: `QSEL_W];
            if (sel_a == `QSEL_DEFAULT) begin
                sel_a = QDEF_A[c*`QSEL_W +: `QSEL_W];
            end
            if (sel_b == `QSEL_DEFAULT) begin
                sel_b = QDEF_B[c*`QSEL_W +: `QSEL_W];
            end
            qa_nxt[c] = pick_pin(pin_lvl & bonded_mask, sel_a);
            qb_nxt[c] = pick_pin(pin_lvl & bonded_mask, sel_b);
        end
    end

    periph_in_select #(
        .NPINS(NPINS),
        .NIDS(NIDS)
    ) u_route (
        .pin_fid(fid_flat),
        .pin_lvl(pin_lvl),
        .pin_en(route_en),
        .id_lvl(id_lvl),
        .id_hit(id_hit)
    );

    // ****************************************************************
    // pad outputs, frozen during sleep
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= {NPINS{1'b0}};
            pin_oe <= {NPINS{1'b0}};
            pin_pu <= {NPINS{1'b0}};
            pin_pd <= {NPINS{1'b0}};
            adc_chan_en <= 4'h0;
            pad_drive_reduced <= 1'b0;
        end else if (!sleep_req) begin
            // holding everything keeps pins at their last state in sleep
            pin_out <= out_nxt & bonded_mask;
            pin_oe <= oe_nxt;
            pin_pu <= pu_nxt & bonded_mask;
            pin_pd <= pd_nxt & bonded_mask;
            adc_chan_en <= adc_nxt;
            pad_drive_reduced <= drive_reduced_r;
        end
    end

    // ****************************************************************
    // inward signals
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_in <= {NIDS{1'b0}};
            periph_in_hit <= {NIDS{1'b0}};
            debug_data_in <= 1'b0;
            debug_clk <= 1'b0;
            hw_reset_req <= 1'b0;
            decoder_phase_a <= {`QDEC_CH{1'b0}};
            decoder_phase_b <= {`QDEC_CH{1'b0}};
        end else begin
            periph_in <= id_lvl;
            periph_in_hit <= id_hit;
            debug_data_in <= (debug_pin_select_r != `DBG_OFF) && dbg_data_nxt;
            debug_clk <= (debug_pin_select_r != `DBG_OFF) &&
                pin_lvl[`PIN_DBG_CLK];
            // active low pin level requests reset
            hw_reset_req <= !hw_reset_pin_off_r && !pin_lvl[`PIN_HW_RESET];
            decoder_phase_a <= qa_nxt;
            decoder_phase_b <= qb_nxt;
        end
    end

    // ****************************************************************
    // apb read path, answered with zero wait states
    // ****************************************************************
    assign rd_map = (paddr <= `ADDR_MODE_LAST && paddr[1:0] == 2'h0) ||
        paddr == `ADDR_DATA || paddr == `ADDR_SET || paddr == `ADDR_CLR ||
        paddr == `ADDR_PAD_CTRL || paddr == `ADDR_SYS_CTRL;

    always @* begin
        rdata_nxt = 32'h00000000;
        err_nxt = !rd_map;
        if (paddr <= `ADDR_MODE_LAST && paddr[1:0] == 2'h0) begin
            rdata_nxt[`MODE_W-1:0] = mode_r[paddr[5:2]*`MODE_W +: `MODE_W];
        end else if (paddr == `ADDR_DATA) begin
            rdata_nxt[NPINS-1:0] = data_view;
        end else if (paddr == `ADDR_PAD_CTRL) begin
            rdata_nxt[`PAD_REDUCED_BIT] = drive_reduced_r;
        end else if (paddr == `ADDR_SYS_CTRL) begin
            rdata_nxt[`SYS_DBG_LSB +: `SYS_DBG_W] = debug_pin_select_r;
            rdata_nxt[`SYS_HWR_OFF_BIT] = hw_reset_pin_off_r;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rdata_nxt;
                pslverr <= err_nxt;
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule // gpio_port_pin_mux
`default_nettype wire

//--- gpio_port_pin_mux_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_consts.vh"
module gpio_port_pin_mux_checker #(
    parameter NPINS = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_pu,
    input wire logic [NPINS-1:0] pin_pd,
    input wire logic [3:0] adc_chan_en,
    input wire logic hw_reset_req,
    input wire logic sleep_req
);
    // ****
    // helpers
    // ****
    // synchroniser flops start at 0, so pin 0 looks low just after reset
    logic [2:0] up_cnt_r;
    logic acc;
    assign acc = psel && penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt_r <= 3'h0;
        end else if (up_cnt_r != 3'h7) begin
            up_cnt_r <= up_cnt_r + 3'h1;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****
    // properties
    // ****
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready low in access phase");
    property p_rdata_hold;
        acc && !pwrite |=> $stable(prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed after access");
    property p_unmapped;
        acc && (paddr > `ADDR_SYS_CTRL || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access without error");
    property p_mapped;
        acc && paddr <= `ADDR_SYS_CTRL && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped)
        else $error("mapped access flagged as error");
    property p_wo_read;
        acc && !pwrite && (paddr == `ADDR_SET || paddr == `ADDR_CLR) |-> prdata == 32'h0;
    endproperty
    a_wo_read: assert property (p_wo_read)
        else $error("set or clear register read nonzero");
    property p_pull_off;
        (pin_oe & (pin_pu | pin_pd)) == '0;
    endproperty
    a_pull_off: assert property (p_pull_off)
        else $error("pull active on driven pin");
    property p_one_pull;
        (pin_pu & pin_pd) == '0;
    endproperty
    a_one_pull: assert property (p_one_pull)
        else $error("pull-up and pull-down together");
    property p_sleep;
        sleep_req ##1 sleep_req |=> $stable(pin_out) && $stable(pin_oe) && $stable(pin_pu);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("pad moved during sleep");
    property p_hw_reset;
        hw_reset_req && up_cnt_r == 3'h7 |-> !$past(pin_in[0], 3);
    endproperty
    a_hw_reset: assert property (p_hw_reset)
        else $error("reset request without low pin");
    property p_analog_read;
        acc && !pwrite && paddr == `ADDR_DATA
            |-> (prdata[7:0] & {adc_chan_en[3:2], 3'h0, adc_chan_en[1:0], 1'b0}) == 8'h0;
    endproperty
    a_analog_read: assert property (p_analog_read)
        else $error("analog pin read nonzero");
    property p_data_width;
        acc && !pwrite && paddr == `ADDR_DATA |-> prdata[31:NPINS] == '0;
    endproperty
    a_data_width: assert property (p_data_width)
        else $error("data read above port width");
endmodule // gpio_port_pin_mux_checker
`default_nettype wire

//--- pad_world.sv
`timescale 1ns/1ps
`default_nettype none
module pad_world #(
    parameter NPINS = 12
) (
    input wire logic pclk,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_pu,
    input wire logic [NPINS-1:0] pin_pd,
    input wire logic [NPINS-1:0] ext_en,
    input wire logic [NPINS-1:0] ext_val,
    output var logic [NPINS-1:0] pin_in
);
    // a floating pad wanders rather than keeping a stale level
    logic flt_r = 1'b0;
    always @(posedge pclk) begin
        flt_r <= ~flt_r;
    end
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pu[i] || pin_pd[i]) begin
                pin_in[i] = pin_pu[i];
            end else begin
                pin_in[i] = flt_r;
            end
        end
    end
endmodule // pad_world
`default_nettype wire

//--- gpio_port_pin_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_consts.vh"
module gpio_port_pin_mux_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, periph_in, periph_in_hit, rd;
    logic pready, pslverr, er, pad_drive_reduced, debug_data_in, debug_clk, hw_reset_req;
    logic [11:0] pin_in, pin_out, pin_oe, pin_pu, pin_pd;
    logic [11:0] ext_en = 12'hFFF;
    logic [11:0] ext_val = 12'hFFF;
    logic [3:0] adc_chan_en;
    logic [31:0] periph_out = 32'h0;
    logic debug_data_out = 1'b0;
    logic debug_data_oe = 1'b0;
    logic [47:0] decoder_channel_pin_select = 48'hFFFF_FFFF_FFFF;
    logic [5:0] decoder_phase_a, decoder_phase_b;
    logic sleep_req = 1'b0;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;

    gpio_port_pin_mux #(.NPINS(12), .BONDED(12), .NIDS(32)) dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out,
        .pin_oe, .pin_pu, .pin_pd, .pad_drive_reduced, .adc_chan_en, .periph_out, .periph_in,
        .periph_in_hit, .debug_data_out, .debug_data_oe, .debug_data_in, .debug_clk,
        .hw_reset_req, .decoder_channel_pin_select, .decoder_phase_a, .decoder_phase_b,
        .sleep_req);
    pad_world #(.NPINS(12)) pads (.pclk, .pin_out, .pin_oe, .pin_pu, .pin_pd, .ext_en,
        .ext_val, .pin_in);

    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            complete_run();
        end
    end
    // ****
    // bus and compare helpers
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge keeps back-to-back calls from assigning psel twice
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    function automatic logic [31:0] md(input logic [1:0] d, input logic [4:0] f);
        return {22'h0, d, 3'h0, f};
    endfunction
    // ****
    // scenarios
    // ****
    task automatic t_reset;
        for (int i = 0; i < 12; i++) begin
            rd_chk(12'(i * 4), 32'h0);
        end
        rd_chk(`ADDR_PAD_CTRL, 32'h0);
        rd_chk(`ADDR_SYS_CTRL, 32'h1);
        chk(32'(pin_oe | pin_pu | pin_pd), 32'h0);
        wr(`ADDR_SYS_CTRL, 32'h4);
        $display("test reset done");
    endtask
    task automatic t_dir;
        int ap[4] = '{1, 2, 6, 7};
        for (int d = 0; d < 4; d++) begin
            wr(12'h00C, md(2'(d), `FID_GPIO));
            tick(2);
            chk({pin_oe[3], pin_pu[3], pin_pd[3]}, 32'((12'h850 >> (3 * d)) & 12'h7));
        end
        foreach (ap[k]) wr(12'(ap[k] * 4), md(`DIR_PU, `FID_ANALOG));
        tick(4);
        chk(adc_chan_en, 32'hF);
        chk(32'(pin_pu & 12'h0C6), 32'h0);
        rd_chk(`ADDR_DATA, 32'hF31);
        foreach (ap[k]) wr(12'(ap[k] * 4), 32'h0);
        $display("test direction done");
    endtask
    task automatic t_data;
        int ap_out[4] = '{3, 4, 8, 9};
        foreach (ap_out[k]) wr(12'(ap_out[k] * 4), md(`DIR_OUT, `FID_GPIO));
        wr(`ADDR_DATA, 32'hFFF);
        tick(2);
        chk(32'(pin_out & 12'h318), 32'h318);
        wr(`ADDR_DATA, 32'h000);
        tick(2);
        chk(32'(pin_out & 12'h318), 32'h0);
        wr(`ADDR_SET, 32'h018);
        tick(2);
        chk(32'(pin_out & 12'h318), 32'h018);
        wr(`ADDR_SET, 32'h100);
        wr(`ADDR_CLR, 32'h008);
        tick(2);
        chk(32'(pin_out & 12'h318), 32'h110);
        rd_chk(`ADDR_SET, 32'h0);
        rd_chk(`ADDR_DATA, 32'hDF7);
        sleep_req <= 1'b1;
        tick(1);
        wr(`ADDR_DATA, 32'h000);
        tick(2);
        chk(32'(pin_out & 12'h318), 32'h110);
        sleep_req <= 1'b0;
        tick(3);
        chk(32'(pin_out & 12'h318), 32'h0);
        wr(12'h020, md(`DIR_OUT, 5'h05));
        wr(12'h024, md(`DIR_OUT, 5'h05));
        periph_out <= 32'h20;
        tick(3);
        chk(pin_out[9:8], 32'h3);
        periph_out <= 32'h0;
        // latch bits set here must not reach pins on a nonzero function
        wr(`ADDR_SET, 32'h300);
        tick(3);
        chk(pin_out[9:8], 32'h0);
        $display("test data done");
    endtask
    task automatic t_input;
        wr(12'h00C, md(`DIR_IN, 5'h07));
        wr(12'h010, md(`DIR_IN, 5'h07));
        ext_val <= 12'hFEF;
        tick(5);
        chk({periph_in_hit[7], periph_in[7]}, 32'h3);
        ext_val <= 12'hFF7;
        tick(5);
        chk({periph_in_hit[7], periph_in[7]}, 32'h2);
        ext_val <= 12'hFFB;
        tick(5);
        chk({decoder_phase_a[0], decoder_phase_b[0]}, 32'h2);
        decoder_channel_pin_select[3:0] <= 4'h3;
        ext_val <= 12'hFF9;
        tick(5);
        chk(decoder_phase_a[0], 32'h1);
        $display("test input routing done");
    endtask
    task automatic t_sys;
        wr(`ADDR_SYS_CTRL, 32'h0);
        ext_val <= 12'hFFE;
        tick(5);
        chk(hw_reset_req, 32'h1);
        wr(`ADDR_SYS_CTRL, 32'h4);
        tick(5);
        chk(hw_reset_req, 32'h0);
        for (int s = 1; s < 4; s++) begin
            wr(`ADDR_SYS_CTRL, 32'(s));
            ext_val <= 12'hBD9 | ((s == 1) ? 12'h024 : (s == 2) ? 12'h002 : 12'h404);
            tick(5);
            chk(debug_data_in, 32'h1);
            chk(debug_clk, 32'(s % 2));
        end
        debug_data_oe <= 1'b1;
        debug_data_out <= 1'b1;
        tick(2);
        chk({pin_oe[10], pin_out[10]}, 32'h3);
        debug_data_oe <= 1'b0;
        wr(`ADDR_SYS_CTRL, 32'h4);
        wr(`ADDR_PAD_CTRL, 32'h1);
        tick(2);
        chk(pad_drive_reduced, 32'h1);
        rd_chk(`ADDR_PAD_CTRL, 32'h1);
        wr(`ADDR_PAD_CTRL, 32'h0);
        tick(2);
        chk(pad_drive_reduced, 32'h0);
        apb(1'b1, 12'h044, 32'hFFFF_FFFF);
        chk(er, 32'h1);
        rd_chk(12'h031, 32'h0);
        chk(er, 32'h1);
        $display("test system control done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_dir();
        t_data();
        t_input();
        t_sys();
        complete_run();
    end
endmodule // gpio_port_pin_mux_tb
bind gpio_port_pin_mux gpio_port_pin_mux_checker #(.NPINS(NPINS)) chk_u (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
    .pin_pu, .pin_pd, .adc_chan_en, .hw_reset_req, .sleep_req);
`default_nettype wire
